// [hdl/adcr_consts.svh]
/*
 * Timing counts and field constants for the parallel readout ADC control block.
 * Assumes a 40 MHz ref_clk; all times are converted to whole cycles here.
 */
// Summary of operation
// - After partial sleep the converter needs at most 20 us to settle before accurate sampling.
// - After full sleep the converter needs at most 500 us to settle before accurate sampling.
// - Valid result data is on the bus no later than 15 ns after the read strobe falls; here result_bus_o updates four ref_clk rising edges later.
// - The bus is released to high impedance within 8 ns after the read strobe rises; here result_bus_o is driven to zero four ref_clk rising edges later.
// - The twelve result outputs are driven only while chip select and read strobe are both asserted; here result_bus_o is driven to zero otherwise.
`ifndef ADCR_CONSTS_SVH
`define ADCR_CONSTS_SVH
`define ADCR_CLK_MHZ 40
`define ADCR_RES_BITS 12
`define ADCR_T_CONV_NS 880
`define ADCR_T_ACQ_NS 120
`define ADCR_T_WAKE_PS_US 20
`define ADCR_T_WAKE_FS_US 500
`define ADCR_CONV_CYC ((`ADCR_T_CONV_NS * `ADCR_CLK_MHZ) / 1000)
`define ADCR_ACQ_CYC ((`ADCR_T_ACQ_NS * `ADCR_CLK_MHZ + 999) / 1000)
`define ADCR_WAKE_PS_CYC (`ADCR_T_WAKE_PS_US * `ADCR_CLK_MHZ)
`define ADCR_WAKE_FS_CYC (`ADCR_T_WAKE_FS_US * `ADCR_CLK_MHZ)
`define ADCR_CNT_W 16
`endif

// [hdl/adcr_pkg.sv]
/*
 * Types for the parallel readout ADC control block.
 * Assumes adcr_consts.svh is available on the include path.
 */
`default_nettype none
`include "adcr_consts.svh"
package adcr_pkg;
    typedef logic [`ADCR_RES_BITS-1:0] adcr_word_t;
    typedef enum logic [1:0] {
        ADCR_IDLE = 2'b00,
        ADCR_CONV = 2'b01,
        ADCR_WAKE = 2'b10
    } adcr_state_t;
    typedef enum logic [1:0] {
        ADCR_AWAKE = 2'b00,
        ADCR_PSLEEP = 2'b01,
        ADCR_FSLEEP = 2'b10
    } adcr_sleep_t;
endpackage : adcr_pkg
`default_nettype wire

// [hdl/adcr_top.sv]
/*
 * Conversion, sleep wake-up and parallel readout sequencing of a 12-bit SAR ADC.
 * Assumes host strobes are asynchronous pins and the SAR core delivers sample_code
 * as straight binary; a two-entry buffer holds results so a slow reader loses none.
 */
`default_nettype none
`include "adcr_consts.svh"
module adcr_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic conversion_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic sleep_req,
    input wire logic sleep_full,
    input wire adcr_pkg::adcr_word_t sample_code,
    output logic busy,
    output logic settled,
    output logic result_ready,
    output adcr_pkg::adcr_word_t result_bus_o,
    output logic result_bus_oe,
    output logic result_pending
);
    import adcr_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [1:0] cs_s1;
        logic [1:0] cs_s2;
        logic [1:0] rd_s1;
        logic [1:0] rd_s2;
        logic [1:0] cv_s1;
        logic [1:0] cv_s2;
        logic [1:0] sl_s1;
        logic [1:0] sl_s2;
        logic cv_prev;
        logic rd_act_prev;
        adcr_state_t st;
        adcr_sleep_t sleep;
        logic [`ADCR_CNT_W-1:0] cnt;
        logic [`ADCR_CNT_W-1:0] wake_cnt;
        logic settled;
        adcr_word_t [1:0] buf_data;
        logic [1:0] buf_vld;
        logic buf_wr;
        logic buf_rd;
        adcr_word_t out_data;
        logic out_oe;
    } adcr_regs_t;

    adcr_regs_t state_reg;
    adcr_regs_t state_next;

    logic cv_fall;
    logic rd_active;
    logic rd_end;
    logic push_valid;
    logic push_ready;
    logic pop_valid;

    // ****************************************
    // Handshake terms
    // ****************************************
    assign cv_fall = state_reg.cv_prev & ~state_reg.cv_s2[0];
    assign rd_active = ~state_reg.cs_s2[0] & ~state_reg.rd_s2[0];
    assign rd_end = state_reg.rd_act_prev & ~rd_active;
    assign push_ready = ~state_reg.buf_vld[state_reg.buf_wr];
    assign pop_valid = state_reg.buf_vld[state_reg.buf_rd];
    assign push_valid = (state_reg.st == ADCR_CONV) && (state_reg.cnt == `ADCR_CNT_W'(1));

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        state_next.cs_s1 = {state_reg.cs_s1[0], cs_n};
        state_next.cs_s2 = {state_reg.cs_s2[0], state_reg.cs_s1[1]};
        state_next.rd_s1 = {state_reg.rd_s1[0], rd_n};
        state_next.rd_s2 = {state_reg.rd_s2[0], state_reg.rd_s1[1]};
        state_next.cv_s1 = {state_reg.cv_s1[0], conversion_start_n};
        state_next.cv_s2 = {state_reg.cv_s2[0], state_reg.cv_s1[1]};
        state_next.sl_s1 = {sleep_full, sleep_req};
        state_next.sl_s2 = state_reg.sl_s1;
        state_next.cv_prev = state_reg.cv_s2[0];
        state_next.rd_act_prev = rd_active;
        if (state_reg.wake_cnt != '0) begin
            state_next.wake_cnt = state_reg.wake_cnt - `ADCR_CNT_W'(1);
        end
        if (state_reg.wake_cnt == `ADCR_CNT_W'(1)) begin
            state_next.settled = 1'b1;
        end
        case (state_reg.st)
            ADCR_IDLE: begin
                if (cv_fall && push_ready) begin
                    state_next.st = ADCR_CONV;
                    state_next.cnt = `ADCR_CNT_W'(`ADCR_CONV_CYC);
                end else if (state_reg.sl_s2[0] && (state_reg.wake_cnt == '0)) begin
                    state_next.sleep = state_reg.sl_s2[1] ? ADCR_FSLEEP : ADCR_PSLEEP;
                    state_next.settled = 1'b0;
                end else if (state_reg.sleep != ADCR_AWAKE) begin
                    state_next.st = ADCR_WAKE;
                    state_next.wake_cnt = (state_reg.sleep == ADCR_FSLEEP) ?
                        `ADCR_CNT_W'(`ADCR_WAKE_FS_CYC) : `ADCR_CNT_W'(`ADCR_WAKE_PS_CYC);
                    state_next.sleep = ADCR_AWAKE;
                end
            end
            ADCR_CONV: begin
                state_next.cnt = state_reg.cnt - `ADCR_CNT_W'(1);
                if (push_valid) begin
                    state_next.st = ADCR_IDLE;
                end
            end
            ADCR_WAKE: begin
                if (cv_fall && push_ready) begin
                    state_next.st = ADCR_CONV;
                    state_next.cnt = `ADCR_CNT_W'(`ADCR_CONV_CYC);
                end else if (state_reg.wake_cnt == `ADCR_CNT_W'(1)) begin
                    state_next.st = ADCR_IDLE;
                end
            end
            default: begin
                state_next.st = ADCR_IDLE;
            end
        endcase
        if (push_valid && push_ready) begin
            state_next.buf_data[state_reg.buf_wr] = sample_code;
            state_next.buf_vld[state_reg.buf_wr] = 1'b1;
            state_next.buf_wr = ~state_reg.buf_wr;
        end
        if (rd_active && pop_valid && !state_reg.rd_act_prev) begin
            state_next.out_data = state_reg.buf_data[state_reg.buf_rd];
        end
        if (rd_end && pop_valid) begin
            state_next.buf_vld[state_reg.buf_rd] = 1'b0;
            state_next.buf_rd = ~state_reg.buf_rd;
        end
        state_next.out_oe = rd_active;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{cs_s1: 2'h3, cs_s2: 2'h3, rd_s1: 2'h3, rd_s2: 2'h3,
                           cv_s1: 2'h3, cv_s2: 2'h3, cv_prev: 1'b1, st: ADCR_IDLE,
                           sleep: ADCR_AWAKE, settled: 1'b1, default: '0};
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign busy = (state_reg.st == ADCR_CONV);
    assign settled = state_reg.settled;
    assign result_ready = pop_valid;
    assign result_pending = pop_valid;
    assign result_bus_o = state_reg.out_oe ? state_reg.out_data : '0;
    assign result_bus_oe = state_reg.out_oe;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_start;
        (state_reg.st == ADCR_IDLE) && cv_fall && push_ready;
    endsequence
    property p_busy_rise;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en) s_start |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("Busy did not rise on start");
    property p_busy_len;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en) $rose(busy) |-> busy [*8] ##27 busy ##1 !busy;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("Conversion length wrong");
    property p_oe_rd;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en) result_bus_oe == $past(rd_active);
    endproperty
    a_oe_rd: assert property (p_oe_rd) else $error("Bus enable not tied to strobes");
    property p_release;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en) rd_end |=> !result_bus_oe;
    endproperty
    a_release: assert property (p_release) else $error("Bus not released");
    property p_data;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en)
            (rd_active && pop_valid && !state_reg.rd_act_prev) |=> result_bus_o == $past(state_reg.buf_data[state_reg.buf_rd]);
    endproperty
    a_data: assert property (p_data) else $error("Read data wrong");
    property p_code;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en)
            (push_valid && push_ready) |=> state_reg.buf_data[$past(state_reg.buf_wr)] == $past(sample_code);
    endproperty
    a_code: assert property (p_code) else $error("Result code altered");
    property p_busy_refused;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en)
            ((state_reg.st == ADCR_IDLE) && cv_fall && !push_ready) |=> !busy;
    endproperty
    a_busy_refused: assert property (p_busy_refused) else $error("Start taken with buffer full");
    property p_wake;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en)
            (state_reg.wake_cnt == `ADCR_CNT_W'(1)) |=> settled;
    endproperty
    a_wake: assert property (p_wake) else $error("Not settled after wake-up");
    sequence s_wake_entry;
        (state_reg.st == ADCR_IDLE) && (state_reg.sleep != ADCR_AWAKE) && !state_reg.sl_s2[0] && !cv_fall;
    endsequence
    property p_wake_ps;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en)
            (state_reg.sleep == ADCR_PSLEEP) ##0 s_wake_entry
            |=> state_reg.wake_cnt == `ADCR_CNT_W'(`ADCR_WAKE_PS_CYC);
    endproperty
    a_wake_ps: assert property (p_wake_ps) else $error("Partial sleep wake count wrong");
    property p_wake_fs;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en)
            (state_reg.sleep == ADCR_FSLEEP) ##0 s_wake_entry
            |=> state_reg.wake_cnt == `ADCR_CNT_W'(`ADCR_WAKE_FS_CYC);
    endproperty
    a_wake_fs: assert property (p_wake_fs) else $error("Full sleep wake count wrong");
    property p_sleep_entry;
        @(posedge ref_clk) disable iff (!rst_n || !clk_en)
            ((state_reg.st == ADCR_IDLE) && state_reg.sl_s2[0] && (state_reg.wake_cnt == '0) && !cv_fall)
            |=> !settled;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("Settled kept on sleep entry");
    property p_freeze;
        @(posedge ref_clk) disable iff (!rst_n) !clk_en |=> $stable(state_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved while clock enable low");
endmodule : adcr_top
`default_nettype wire

// [bench/adcr_host.sv]
/*
 * Host bus controller model driving the start strobe, chip select and read strobe.
 * Assumes the bench calls its tasks and keeps starts spaced.
 */
`default_nettype none
module adcr_host (
    input wire logic ref_clk,
    output var logic conversion_start_n,
    output var logic cs_n,
    output var logic rd_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        conversion_start_n = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
    end
    // **********
    // Strobes
    // **********
    // Start pulse of two cycles; the caller spaces starts
    task automatic start_conv();
        @(negedge ref_clk) conversion_start_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        conversion_start_n = 1'b1;
    endtask : start_conv
    // Select and read strobes, driven at the next falling edge of ref_clk after the caller asks
    task automatic drive(input logic c, input logic r);
        @(negedge ref_clk);
        cs_n = c;
        rd_n = r;
    endtask : drive
endmodule : adcr_host
`default_nettype wire

// [bench/adcr_parallel_readout_timing_test.sv]
/*
 * Self-checking bench: conversion, two-entry buffer, readout and wake-up.
 * Assumes adcr_consts.svh on the include path and adcr_pkg compiled first.
 */
`default_nettype none
`include "adcr_consts.svh"
module adcr_parallel_readout_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    import adcr_pkg::*;
    localparam int F_BUSY = 0;
    localparam int F_OE = 1;
    localparam int F_SETTLED = 2;
    logic ref_clk = 1'b0, rst_n = 1'b0, sleep_req = 1'b0, sleep_full = 1'b0, clk_en = 1'b1;
    logic conv_n, cs_n, rd_n, busy, settled, ready, oe, pend;
    adcr_word_t sample_code = 12'h000, bus;
    int failures = 0, comparisons = 0;
    always #12.5 ref_clk = ~ref_clk;
    adcr_host host (.ref_clk(ref_clk), .conversion_start_n(conv_n), .cs_n(cs_n), .rd_n(rd_n));
    adcr_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .conversion_start_n(conv_n),
        .cs_n(cs_n), .rd_n(rd_n), .sleep_req(sleep_req), .sleep_full(sleep_full),
        .sample_code(sample_code), .busy(busy), .settled(settled), .result_ready(ready),
        .result_bus_o(bus), .result_bus_oe(oe), .result_pending(pend));
    // **********
    // Helpers
    // **********
    task automatic complete_run();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic check(input adcr_word_t seen, input adcr_word_t exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic flag(input int sel);
        case (sel)
            F_BUSY: return busy;
            F_OE: return oe;
            default: return settled;
        endcase
    endfunction : flag
    task automatic wait_flag(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while (flag(sel) !== v && n < lim) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask : wait_flag
    // **********
    // Scenarios
    // **********
    task automatic convert(input adcr_word_t code);
        int n;
        @(negedge ref_clk) sample_code = code;
        host.start_conv();
        wait_flag(F_BUSY, 1'b1, 8, n);
        check(busy, 1);
        wait_flag(F_BUSY, 1'b0, 40, n);
        check(n, `ADCR_CONV_CYC);
        repeat (`ADCR_ACQ_CYC) @(posedge ref_clk);
    endtask : convert
    task automatic freeze_conv(input adcr_word_t code);
        int n;
        @(negedge ref_clk) sample_code = code;
        host.start_conv();
        wait_flag(F_BUSY, 1'b1, 8, n);
        @(negedge ref_clk) clk_en = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1 check(busy, 1);
        check(ready, 0);
        @(negedge ref_clk) clk_en = 1'b1;
        wait_flag(F_BUSY, 1'b0, 60, n);
        check(n, `ADCR_CONV_CYC);
        repeat (`ADCR_ACQ_CYC) @(posedge ref_clk);
    endtask : freeze_conv
    task automatic read_word(input adcr_word_t exp);
        int n;
        host.drive(1'b0, 1'b1);
        repeat (5) @(posedge ref_clk);
        #1 check(oe, 0);
        host.drive(1'b0, 1'b0);
        wait_flag(F_OE, 1'b1, 8, n);
        check(oe, 1);
        check(bus, exp);
        host.drive(1'b1, 1'b1);
        wait_flag(F_OE, 1'b0, 8, n);
        check(oe, 0);
        check(bus, 0);
    endtask : read_word
    task automatic sleep_wake(input logic full, input int lim, input logic early);
        int n;
        @(negedge ref_clk);
        sleep_full = full;
        sleep_req = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 check(settled, 0);
        @(negedge ref_clk) sleep_req = 1'b0;
        if (early) begin
            convert(12'h3c1);
            check(settled, 0);
            read_word(12'h3c1);
        end
        wait_flag(F_SETTLED, 1'b1, lim + 10, n);
        check(settled, 1);
        if (!early) begin
            check((n >= lim) && (n <= lim + 4), 1);
        end
    endtask : sleep_wake
    initial begin
        #1ms;
        failures++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1'b1;
        #1 check(busy, 0);
        check(oe, 0);
        check(settled, 1);
        check(ready, 0);
        check(pend, 0);
        convert(12'h000);
        convert(12'hfff);
        host.start_conv();
        repeat (40) @(posedge ref_clk);
        #1 check(busy, 0);
        check(ready, 1);
        check(pend, 1);
        read_word(12'h000);
        read_word(12'hfff);
        check(ready, 0);
        check(pend, 0);
        convert(12'h5a3);
        read_word(12'h5a3);
        freeze_conv(12'ha5c);
        read_word(12'ha5c);
        sleep_wake(1'b0, `ADCR_WAKE_PS_CYC, 1'b0);
        sleep_wake(1'b0, `ADCR_WAKE_PS_CYC, 1'b1);
        sleep_wake(1'b1, `ADCR_WAKE_FS_CYC, 1'b0);
        complete_run();
    end
endmodule : adcr_parallel_readout_timing_test
`default_nettype wire
